/* File: verilog/srs_params.svh */
// Constants of the serial register access link: frame codes, frame sizes,
// checksum seed and polynomial, timing counts.
// Assumes inclusion by the package and both ends; plain definitions only.
//
// Overview of operation
// (RULE_01) Full-duplex link, separate transmit and receive pairs
// (RULE_02) Shared line; drive answers only own frames
// (RULE_03) First byte is node identifier; match required
// (RULE_04) Bit rate from setting; both ends equal
// (RULE_05) Read request: id, 03, address, count, CRC
// (RULE_06) Read reply: id, 03, 2N, words, CRC
// (RULE_07) Write request 06; drive writes, echoes frame
// (RULE_08) Modbus CRC-16; bad frames silently dropped
`ifndef SRS_PARAMS_SVH
`define SRS_PARAMS_SVH

`define SRS_FN_READ      8'h03
`define SRS_FN_WRITE     8'h06
`define SRS_REQ_LEN      4'h8
`define SRS_CRC_INIT     16'hFFFF
`define SRS_CRC_POLY     16'hA001
`define SRS_MAX_NODES    32
`define SRS_MAX_REGS     16
`define SRS_GAP_BITS     22'h000023
`define SRS_RSP_TIMEOUT  250000

`endif

/* File: verilog/srs_pkg.sv */
// Types and the frame checksum shared by both ends of the link.
// Assumes srs_params.svh on the include path.
`include "srs_params.svh"

package srs_pkg;

  typedef enum logic [3:0] {
    DEV_IDLE  = 4'b0000,
    DEV_CHECK = 4'b0001,
    DEV_ECHO  = 4'b0010,
    DEV_HDR   = 4'b0011,
    DEV_FETCH = 4'b0100,
    DEV_WAIT  = 4'b0101,
    DEV_LATCH = 4'b0110,
    DEV_DATA  = 4'b0111,
    DEV_CRC   = 4'b1000,
    DEV_DRAIN = 4'b1001
  } srs_dev_state_e;

  typedef enum logic [1:0] {
    HST_IDLE = 2'b00,
    HST_SEND = 2'b01,
    HST_WAIT = 2'b10
  } srs_hst_state_e;

  // Serial byte engine shared in shape by both ends
  typedef struct packed {
    logic        rx_busy;
    logic [3:0]  rx_bit;
    logic [15:0] rx_cnt;
    logic [7:0]  rx_sh;
    logic        tx_busy;
    logic [3:0]  tx_bit;
    logic [15:0] tx_cnt;
    logic [9:0]  tx_sh;
    logic        txd;
  } srs_uart_s;

  typedef struct packed {
    srs_dev_state_e st;
    srs_uart_s      u;
    logic           oe_n;
    logic [21:0]    gap;
    logic [3:0]     idx;
    logic [3:0]     k;
    logic [7:0][7:0] buf_b;
    logic [15:0]    crc;
    logic [15:0]    addr;
    logic [7:0]     left;
    logic           lo;
    logic [15:0]    word;
    logic           rd;
    logic           wr;
    logic [15:0]    wdata;
  } srs_dev_s;

  typedef struct packed {
    srs_hst_state_e st;
    srs_uart_s      u;
    logic           ready;
    logic [5:0][7:0] req;
    logic [3:0]     k;
    logic [8:0]     j;
    logic [8:0]     len;
    logic [15:0]    crc;
    logic [7:0]     crc_hi;
    logic [7:0]     word_hi;
    logic           err;
    logic [31:0]    tmo;
    logic           word_valid;
    logic [15:0]    word;
    logic           done;
    logic [1:0]     status;
  } srs_hst_s;

  // One byte of the Modbus CRC-16, reflected form
  function automatic logic [15:0] srs_crc_byte(input logic [15:0] crc,
                                               input logic [7:0]  b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ `SRS_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : srs_crc_byte

endpackage : srs_pkg

/* File: verilog/srs_link_if.sv */
// Two-pair serial link between controller and drive.
// Assumes the bench models further drives by their own enables.
`timescale 1ns/1ps
`default_nettype none

interface srs_link_if;
  logic ctl_txd;       // Controller transmit pair, drive receive
  logic dev_txd;       // Drive transmit data
  logic dev_txd_oe_n;  // Drive transmit enable, low while driving
  logic dev_line;      // Resolved drive-to-controller pair

  // Undriven shared pair idles at mark level
  assign dev_line = dev_txd_oe_n ? 1'b1 : dev_txd;

  modport device (input ctl_txd, output dev_txd, output dev_txd_oe_n);
  modport host   (output ctl_txd, input dev_line);
endinterface : srs_link_if

`default_nettype wire

/* File: verilog/srs_host.sv */
// Controller end: sends one request frame per command, checks the answer.
// Assumes line_rate_setting_i (cycles per bit, at least 3) equals the
// drive's setting and stays fixed during a transfer.
`timescale 1ns/1ps
`default_nettype none
`include "srs_params.svh"

module srs_host #(
  parameter int unsigned RSP_TIMEOUT = `SRS_RSP_TIMEOUT
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  // Link
  srs_link_if.host         link,
  // Settings
  input  wire logic [15:0] line_rate_setting_i,
  // Command
  input  wire logic        cmd_valid_i,
  output logic             cmd_ready_o,
  input  wire logic [7:0]  cmd_node_i,
  input  wire logic [7:0]  cmd_fn_i,
  input  wire logic [15:0] cmd_addr_i,
  input  wire logic [15:0] cmd_arg_i,
  // Answer
  output logic             rsp_word_valid_o,
  output logic [15:0]      rsp_word_o,
  output logic             done_o,
  output logic [1:0]       done_status_o
);

  srs_pkg::srs_hst_s r_reg;
  srs_pkg::srs_hst_s r_next;
  logic              rx_done;
  logic              ld;
  logic [7:0]        ld_byte;
  logic [7:0]        rxb;

  always_comb begin
    r_next = r_reg;
    rx_done = 1'b0;
    ld = 1'b0;
    ld_byte = 8'h00;
    rxb = r_reg.u.rx_sh;
    r_next.word_valid = 1'b0;
    r_next.done = 1'b0;
    // Receiver, samples mid-bit on the resolved pair
    if (!r_reg.u.rx_busy) begin
      if (!link.dev_line) begin
        r_next.u.rx_busy = 1'b1;
        r_next.u.rx_bit = 4'h0;
        r_next.u.rx_cnt = {1'b0, line_rate_setting_i[15:1]};  // RULE_04
      end
    end else if (r_reg.u.rx_cnt != 16'h0000) begin
      r_next.u.rx_cnt = r_reg.u.rx_cnt - 16'h0001;
    end else begin
      r_next.u.rx_cnt = line_rate_setting_i - 16'h0001;
      r_next.u.rx_bit = r_reg.u.rx_bit + 4'h1;
      if (r_reg.u.rx_bit == 4'h0) begin
        if (link.dev_line) r_next.u.rx_busy = 1'b0;  // Glitch, not a start
      end else if (r_reg.u.rx_bit < 4'h9) begin
        r_next.u.rx_sh = {link.dev_line, r_reg.u.rx_sh[7:1]};
      end else begin
        r_next.u.rx_busy = 1'b0;
        rx_done = link.dev_line;  // Framing error drops the byte
      end
    end
    // Command sequencer
    case (r_reg.st)
      srs_pkg::HST_IDLE: begin
        r_next.ready = 1'b1;
        if (cmd_valid_i && r_reg.ready) begin
          r_next.ready = 1'b0;
          r_next.req = {cmd_arg_i[7:0], cmd_arg_i[15:8], cmd_addr_i[7:0],
                        cmd_addr_i[15:8], cmd_fn_i, cmd_node_i};  // RULE_05
          r_next.k = 4'h0;
          r_next.crc = `SRS_CRC_INIT;
          r_next.st = srs_pkg::HST_SEND;
        end
      end
      srs_pkg::HST_SEND: begin
        if (!r_reg.u.tx_busy) begin
          ld = 1'b1;
          r_next.k = r_reg.k + 4'h1;
          if (r_reg.k < 4'h6) begin
            ld_byte = r_reg.req[r_reg.k[2:0]];  // RULE_03
            r_next.crc = srs_pkg::srs_crc_byte(r_reg.crc, ld_byte);
          end else if (r_reg.k == 4'h6) begin
            ld_byte = r_reg.crc[15:8];  // RULE_08
          end else begin
            ld_byte = r_reg.crc[7:0];
            r_next.st = srs_pkg::HST_WAIT;
            r_next.j = 9'h000;
            r_next.len = 9'h008;
            r_next.err = 1'b0;
            r_next.tmo = 32'h00000000;
            r_next.crc = `SRS_CRC_INIT;
          end
        end
      end
      srs_pkg::HST_WAIT: begin
        r_next.tmo = r_reg.tmo + 32'h00000001;
        if (rx_done) begin
          r_next.tmo = 32'h00000000;
          r_next.j = r_reg.j + 9'h001;
          if (r_reg.j < r_reg.len - 9'h002) begin
            r_next.crc = srs_pkg::srs_crc_byte(r_reg.crc, rxb);
          end
          if (r_reg.j < 9'h002 && rxb != r_reg.req[r_reg.j[0]]) begin
            r_next.err = 1'b1;  // RULE_02
          end
          if (r_reg.j == 9'h002 && r_reg.req[1] == `SRS_FN_READ) begin
            r_next.len = {1'b0, rxb} + 9'h005;  // RULE_06
          end
          if (r_reg.req[1] == `SRS_FN_READ && r_reg.j >= 9'h003
              && r_reg.j < r_reg.len - 9'h002) begin
            if (r_reg.j[0]) begin
              r_next.word_hi = rxb;
            end else begin
              r_next.word = {r_reg.word_hi, rxb};
              r_next.word_valid = 1'b1;
            end
          end
          if (r_reg.j == r_reg.len - 9'h002) r_next.crc_hi = rxb;
          if (r_reg.j == r_reg.len - 9'h001) begin
            r_next.done = 1'b1;
            r_next.status = (r_reg.err || {r_reg.crc_hi, rxb} != r_reg.crc)
                            ? 2'h1 : 2'h0;  // RULE_08
            r_next.st = srs_pkg::HST_IDLE;
          end
        end else if (r_reg.tmo == 32'(RSP_TIMEOUT - 1)) begin
          r_next.done = 1'b1;  // Silence: wrong node or dropped frame
          r_next.status = 2'h2;
          r_next.st = srs_pkg::HST_IDLE;
        end
      end
      default: r_next.st = srs_pkg::HST_IDLE;
    endcase
    // Transmitter, 8N1 on its own pair
    if (ld) begin
      r_next.u.tx_sh = {1'b1, ld_byte, 1'b0};
      r_next.u.tx_busy = 1'b1;
      r_next.u.tx_bit = 4'h0;
      r_next.u.tx_cnt = line_rate_setting_i - 16'h0001;
      r_next.u.txd = 1'b0;  // RULE_01
    end else if (r_reg.u.tx_busy) begin
      if (r_reg.u.tx_cnt != 16'h0000) begin
        r_next.u.tx_cnt = r_reg.u.tx_cnt - 16'h0001;
      end else begin
        r_next.u.tx_cnt = line_rate_setting_i - 16'h0001;
        if (r_reg.u.tx_bit == 4'h9) begin
          r_next.u.tx_busy = 1'b0;
        end else begin
          r_next.u.tx_bit = r_reg.u.tx_bit + 4'h1;
          r_next.u.tx_sh = {1'b1, r_reg.u.tx_sh[9:1]};
          r_next.u.txd = r_reg.u.tx_sh[1];
        end
      end
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_reg <= '0;
      r_reg.u.txd <= 1'b1;
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  assign link.ctl_txd     = r_reg.u.txd;
  assign cmd_ready_o      = r_reg.ready;
  assign rsp_word_valid_o = r_reg.word_valid;
  assign rsp_word_o       = r_reg.word;
  assign done_o           = r_reg.done;
  assign done_status_o    = r_reg.status;

endmodule : srs_host

`default_nettype wire

/* File: verilog/srs_device.sv */
// Drive end: decodes request frames and serves register read and write.
// Assumes a register space on the user side that answers a read one
// cycle after the read strobe, and a controller at the same bit rate.
`timescale 1ns/1ps
`default_nettype none
`include "srs_params.svh"

module srs_device #(
  parameter int unsigned MAX_REGS = `SRS_MAX_REGS
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  // Link
  srs_link_if.device       link,
  // Settings
  input  wire logic [7:0]  node_identifier_setting_i,
  input  wire logic [15:0] line_rate_setting_i,
  // Register space
  output logic [15:0]      reg_addr_o,
  output logic             reg_rd_o,
  input  wire logic [15:0] reg_rdata_i,
  output logic             reg_wr_o,
  output logic [15:0]      reg_wdata_o
);

  srs_pkg::srs_dev_s r_reg;
  srs_pkg::srs_dev_s r_next;
  logic              rx_done;
  logic              ld;
  logic              ld_crc;
  logic [7:0]        ld_byte;
  logic [7:0]        rxb;
  logic [21:0]       gap_lim;
  logic              hit;

  always_comb begin
    r_next = r_reg;
    rx_done = 1'b0;
    ld = 1'b0;
    ld_crc = 1'b1;
    ld_byte = 8'h00;
    rxb = r_reg.u.rx_sh;
    r_next.rd = 1'b0;
    r_next.wr = 1'b0;
    // Silence of 3.5 characters marks a frame boundary
    gap_lim = 22'({6'h00, line_rate_setting_i} * `SRS_GAP_BITS);
    hit = r_reg.buf_b[0] == node_identifier_setting_i
          && r_reg.crc == {r_reg.buf_b[6], r_reg.buf_b[7]};
    // Receiver, samples mid-bit
    if (!r_reg.u.rx_busy) begin
      if (!link.ctl_txd) begin
        r_next.u.rx_busy = 1'b1;
        r_next.u.rx_bit = 4'h0;
        r_next.u.rx_cnt = {1'b0, line_rate_setting_i[15:1]};  // RULE_04
      end
    end else if (r_reg.u.rx_cnt != 16'h0000) begin
      r_next.u.rx_cnt = r_reg.u.rx_cnt - 16'h0001;
    end else begin
      r_next.u.rx_cnt = line_rate_setting_i - 16'h0001;
      r_next.u.rx_bit = r_reg.u.rx_bit + 4'h1;
      if (r_reg.u.rx_bit == 4'h0) begin
        if (link.ctl_txd) r_next.u.rx_busy = 1'b0;
      end else if (r_reg.u.rx_bit < 4'h9) begin
        r_next.u.rx_sh = {link.ctl_txd, r_reg.u.rx_sh[7:1]};
      end else begin
        r_next.u.rx_busy = 1'b0;
        rx_done = link.ctl_txd;
      end
    end
    // Gap timer runs only while the line is quiet
    if (r_reg.u.rx_busy || rx_done) begin
      r_next.gap = 22'h000000;
    end else if (r_reg.gap != gap_lim) begin
      r_next.gap = r_reg.gap + 22'h000001;
    end
    case (r_reg.st)
      srs_pkg::DEV_IDLE: begin
        r_next.oe_n = 1'b1;
        if (rx_done) begin
          r_next.buf_b[r_reg.idx[2:0]] = rxb;
          r_next.idx = r_reg.idx + 4'h1;
          if (r_reg.idx == 4'h0) begin
            r_next.crc = srs_pkg::srs_crc_byte(`SRS_CRC_INIT, rxb);
          end else if (r_reg.idx < 4'h6) begin
            r_next.crc = srs_pkg::srs_crc_byte(r_reg.crc, rxb);  // RULE_08
          end
          if (r_reg.idx == `SRS_REQ_LEN - 4'h1) begin
            r_next.st = srs_pkg::DEV_CHECK;  // RULE_05
          end
        end else if (r_reg.gap == gap_lim) begin
          r_next.idx = 4'h0;  // Resync after foreign or broken frames
        end
      end
      srs_pkg::DEV_CHECK: begin
        r_next.idx = 4'h0;
        r_next.k = 4'h0;
        r_next.addr = {r_reg.buf_b[2], r_reg.buf_b[3]};
        r_next.left = r_reg.buf_b[5];
        r_next.st = srs_pkg::DEV_IDLE;
        if (!hit) begin
          r_next.st = srs_pkg::DEV_IDLE;  // RULE_02 RULE_03 RULE_08
        end else if (r_reg.buf_b[1] == `SRS_FN_WRITE) begin
          r_next.wr = 1'b1;  // RULE_07
          r_next.wdata = {r_reg.buf_b[4], r_reg.buf_b[5]};
          r_next.st = srs_pkg::DEV_ECHO;
        end else if (r_reg.buf_b[1] == `SRS_FN_READ
                     && r_reg.buf_b[4] == 8'h00 && r_reg.buf_b[5] != 8'h00
                     && {8'h00, r_reg.buf_b[5]} <= 16'(MAX_REGS)) begin
          r_next.st = srs_pkg::DEV_HDR;
        end
        if (hit) begin
          r_next.crc = `SRS_CRC_INIT;
          r_next.oe_n = 1'b0;  // Take the shared pair on every own frame with a good check word, for one cycle when it is refused
        end
      end
      srs_pkg::DEV_ECHO: begin
        if (!r_reg.u.tx_busy) begin
          ld = 1'b1;
          ld_byte = r_reg.buf_b[r_reg.k[2:0]];  // RULE_07
          r_next.k = r_reg.k + 4'h1;
          if (r_reg.k == 4'h5) begin
            r_next.k = 4'h0;
            r_next.st = srs_pkg::DEV_CRC;
          end
        end
      end
      srs_pkg::DEV_HDR: begin
        if (!r_reg.u.tx_busy) begin
          ld = 1'b1;
          r_next.k = r_reg.k + 4'h1;
          if (r_reg.k == 4'h0) begin
            ld_byte = node_identifier_setting_i;  // RULE_03
          end else if (r_reg.k == 4'h1) begin
            ld_byte = `SRS_FN_READ;
          end else begin
            ld_byte = {r_reg.left[6:0], 1'b0};  // RULE_06
            r_next.st = srs_pkg::DEV_FETCH;
          end
        end
      end
      srs_pkg::DEV_FETCH: begin
        r_next.rd = 1'b1;
        r_next.st = srs_pkg::DEV_WAIT;
      end
      srs_pkg::DEV_WAIT: r_next.st = srs_pkg::DEV_LATCH;
      srs_pkg::DEV_LATCH: begin
        r_next.word = reg_rdata_i;
        r_next.lo = 1'b0;
        r_next.st = srs_pkg::DEV_DATA;
      end
      srs_pkg::DEV_DATA: begin
        if (!r_reg.u.tx_busy) begin
          ld = 1'b1;
          ld_byte = r_reg.lo ? r_reg.word[7:0] : r_reg.word[15:8];  // RULE_06
          r_next.lo = 1'b1;
          if (r_reg.lo) begin
            r_next.addr = r_reg.addr + 16'h0001;  // Ascending addresses
            r_next.left = r_reg.left - 8'h01;
            r_next.k = 4'h0;
            r_next.st = (r_reg.left == 8'h01) ? srs_pkg::DEV_CRC
                                              : srs_pkg::DEV_FETCH;
          end
        end
      end
      srs_pkg::DEV_CRC: begin
        if (!r_reg.u.tx_busy) begin
          ld = 1'b1;
          ld_crc = 1'b0;
          ld_byte = r_reg.k[0] ? r_reg.crc[7:0] : r_reg.crc[15:8];  // RULE_08
          r_next.k = r_reg.k + 4'h1;
          if (r_reg.k[0]) r_next.st = srs_pkg::DEV_DRAIN;
        end
      end
      srs_pkg::DEV_DRAIN: begin
        // Hold the pair until the stop bit of the last byte is out
        if (!r_reg.u.tx_busy) begin
          r_next.oe_n = 1'b1;
          r_next.st = srs_pkg::DEV_IDLE;
        end
      end
      default: r_next.st = srs_pkg::DEV_IDLE;
    endcase
    // Transmitter, 8N1
    if (ld) begin
      r_next.u.tx_sh = {1'b1, ld_byte, 1'b0};
      r_next.u.tx_busy = 1'b1;
      r_next.u.tx_bit = 4'h0;
      r_next.u.tx_cnt = line_rate_setting_i - 16'h0001;
      r_next.u.txd = 1'b0;  // RULE_01
      if (ld_crc) r_next.crc = srs_pkg::srs_crc_byte(r_reg.crc, ld_byte);
    end else if (r_reg.u.tx_busy) begin
      if (r_reg.u.tx_cnt != 16'h0000) begin
        r_next.u.tx_cnt = r_reg.u.tx_cnt - 16'h0001;
      end else begin
        r_next.u.tx_cnt = line_rate_setting_i - 16'h0001;
        if (r_reg.u.tx_bit == 4'h9) begin
          r_next.u.tx_busy = 1'b0;
        end else begin
          r_next.u.tx_bit = r_reg.u.tx_bit + 4'h1;
          r_next.u.tx_sh = {1'b1, r_reg.u.tx_sh[9:1]};
          r_next.u.txd = r_reg.u.tx_sh[1];
        end
      end
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_reg <= '0;
      r_reg.u.txd <= 1'b1;
      r_reg.oe_n <= 1'b1;
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  assign link.dev_txd      = r_reg.u.txd;
  assign link.dev_txd_oe_n = r_reg.oe_n;
  assign reg_addr_o        = r_reg.addr;
  assign reg_rd_o          = r_reg.rd;
  assign reg_wr_o          = r_reg.wr;
  assign reg_wdata_o       = r_reg.wdata;

endmodule : srs_device

`default_nettype wire

/* File: verification/srs_link_sva.sv */
// Checker for the link between the controller end and the drive end.
// Assumes the bench runs four clock cycles per bit on this link.
`timescale 1ns/1ps
`default_nettype none

module srs_link_sva (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Link signals
  input wire logic ctl_txd,
  input wire logic dev_txd,
  input wire logic dev_txd_oe_n
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  logic [11:0] low_cnt_reg;

  // Length of one reply; the longest legal one is well under 1792 cycles
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) low_cnt_reg <= 12'h000;
    else low_cnt_reg <= dev_txd_oe_n ? 12'h000 : low_cnt_reg + 12'h001;
  end

  a_reset_idle_line: assert property (
    $rose(rst_n_i) |-> ctl_txd && dev_txd_oe_n)
    else $error("link not idle after reset");
  a_ctl_bit_time: assert property (
    $changed(ctl_txd) |=> $stable(ctl_txd)[*3])
    else $error("request bit shorter than four cycles");
  a_dev_bit_time: assert property (
    $changed(dev_txd) && !dev_txd_oe_n |=> $stable(dev_txd)[*3])
    else $error("reply bit shorter than four cycles");
  a_reply_len_bound: assert property (
    low_cnt_reg < 12'h700)
    else $error("drive holds the line too long");
  a_no_talk_over: assert property (
    !dev_txd_oe_n |-> ctl_txd)
    else $error("drive answers while a request runs");
  a_reply_after_stop: assert property (
    $fell(dev_txd_oe_n) |-> $past(ctl_txd, 1) && $past(ctl_txd, 4))
    else $error("reply starts before the request ended");
  a_reply_stop_last: assert property (
    $rose(dev_txd_oe_n) && !$past(dev_txd_oe_n, 2)
      |-> $past(dev_txd, 1) && $past(dev_txd, 4))
    else $error("reply released without a full stop bit");
  a_reply_start_low: assert property (
    $fell(dev_txd_oe_n) ##1 !dev_txd_oe_n |-> !dev_txd)
    else $error("reply does not open with a start bit");
endmodule : srs_link_sva

`default_nettype wire

/* File: verification/tb.sv */
// Bench: controller and drive joined by one link, and a second drive
// fed by hand-made frames. Assumes four clock cycles per bit.
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam logic [15:0] RATE = 16'h0004;
  localparam logic [7:0]  NODE = 8'h05;
  logic        ref_clk_i, rst_n_i, cmd_valid, cmd_ready, word_v, done;
  logic        reg_rd, reg_wr, oe2_seen;
  logic [7:0]  cmd_node, cmd_fn, dq[$];
  logic [15:0] cmd_addr, cmd_arg, word, reg_addr, reg_rdata, reg_wdata;
  logic [15:0] regs[256], wq[$];
  logic [1:0]  status;
  int          n_errors, cmp_count, n_wr;

  srs_link_if link();
  srs_link_if link2();
  srs_host #(.RSP_TIMEOUT(400)) srs_host_i (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .ce_i(1'b1), .link(link.host),
    .line_rate_setting_i(RATE), .cmd_valid_i(cmd_valid),
    .cmd_ready_o(cmd_ready), .cmd_node_i(cmd_node), .cmd_fn_i(cmd_fn),
    .cmd_addr_i(cmd_addr), .cmd_arg_i(cmd_arg), .rsp_word_valid_o(word_v),
    .rsp_word_o(word), .done_o(done), .done_status_o(status));
  srs_device srs_device_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .ce_i(1'b1), .link(link.device), .node_identifier_setting_i(NODE),
    .line_rate_setting_i(RATE), .reg_addr_o(reg_addr), .reg_rd_o(reg_rd),
    .reg_rdata_i(reg_rdata), .reg_wr_o(reg_wr), .reg_wdata_o(reg_wdata));
  srs_device srs_device_i2 (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .ce_i(1'b1), .link(link2.device), .node_identifier_setting_i(NODE),
    .line_rate_setting_i(RATE), .reg_addr_o(), .reg_rd_o(),
    .reg_rdata_i(16'h0000), .reg_wr_o(), .reg_wdata_o());
  srs_link_sva srs_link_sva_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .ctl_txd(link.ctl_txd), .dev_txd(link.dev_txd),
    .dev_txd_oe_n(link.dev_txd_oe_n));

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  // Register space answers one cycle after the strobe; words collected
  always @(posedge ref_clk_i) begin
    if (reg_rd) reg_rdata <= regs[reg_addr[7:0]];
    if (reg_wr) begin
      regs[reg_addr[7:0]] <= reg_wdata;
      n_wr <= n_wr + 1;
    end
    if (word_v) wq.push_back(word);
    if (!link2.dev_txd_oe_n) oe2_seen <= 1'b1;
  end

  // Reply sniffer: samples each bit in its middle, LSB first
  initial begin
    logic [7:0] b;
    @(posedge rst_n_i);
    forever begin
      @(negedge link.dev_line);
      repeat (2) @(posedge ref_clk_i);
      for (int k = 0; k < 8; k++) begin
        repeat (4) @(posedge ref_clk_i);
        b[k] = link.dev_line;
      end
      repeat (4) @(posedge ref_clk_i);
      check("stop bit", {15'h0000, link.dev_line}, 16'h0001);
      dq.push_back(b);
    end
  end

  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction : crc16

  task automatic check(input string what, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  // Inputs always move one nanosecond after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : tick

  task automatic run_cmd(input logic [7:0] node, fn,
                         input logic [15:0] a, v);
    int i;
    dq.delete();
    wq.delete();
    {cmd_node, cmd_fn, cmd_addr, cmd_arg} = {node, fn, a, v};
    cmd_valid = 1'b1;
    for (i = 0; i < 50 && cmd_ready !== 1'b1; i++) tick(1);
    if (i == 50) begin
      n_errors++;
      give_verdict();
    end
    tick(1);
    cmd_valid = 1'b0;
    for (i = 0; i < 3000 && done !== 1'b1; i++) tick(1);
    if (i == 3000) begin
      n_errors++;
      give_verdict();
    end
    tick(8);
  endtask : run_cmd

  // Appends the check word, high byte first, and compares the wire
  task automatic cmp_frame(input logic [7:0] e[$]);
    logic [15:0] c;
    c = crc16(e);
    e.push_back(c[15:8]);
    e.push_back(c[7:0]);
    check("reply bytes", 16'(dq.size()), 16'(e.size()));
    foreach (e[i]) check("reply byte", {8'h00, dq[i]}, {8'h00, e[i]});
  endtask : cmp_frame

  task automatic t_read(input logic [15:0] a, input logic [7:0] n);
    logic [7:0] e[$];
    logic [7:0] r;
    run_cmd(NODE, 8'h03, a, {8'h00, n});
    check("status", {14'h0000, status}, 16'h0000);
    check("words", 16'(wq.size()), {8'h00, n});
    e = '{NODE, 8'h03, {n[6:0], 1'b0}};
    for (int k = 0; k < n; k++) begin
      r = a[7:0] + k[7:0];
      check("word", wq[k], regs[r]);
      e.push_back(regs[r][15:8]);
      e.push_back(regs[r][7:0]);
    end
    cmp_frame(e);
  endtask : t_read

  task automatic t_write(input logic [15:0] a, v);
    int w;
    w = n_wr;
    run_cmd(NODE, 8'h06, a, v);
    check("status", {14'h0000, status}, 16'h0000);
    check("writes", 16'(n_wr - w), 16'h0001);
    check("stored", regs[a[7:0]], v);
    cmp_frame('{NODE, 8'h06, a[15:8], a[7:0], v[15:8], v[7:0]});
  endtask : t_write

  // A frame for another drive is met with silence and no access
  task automatic t_other_node();
    int w;
    w = n_wr;
    run_cmd(NODE + 8'h01, 8'h06, 16'h0002, 16'h1234);
    check("status", {14'h0000, status}, 16'h0002);
    check("silent", 16'(dq.size()), 16'h0000);
    check("writes", 16'(n_wr - w), 16'h0000);
  endtask : t_other_node

  // Own node, good check word, but a count or code the drive refuses
  task automatic t_refused(input logic [7:0] fn, input logic [15:0] v);
    run_cmd(NODE, fn, 16'h0000, v);
    check("refused", {14'h0000, status}, 16'h0002);
    check("no reply", 16'(dq.size()), 16'h0000);
  endtask : t_refused

  task automatic send2(input logic [15:0] flip);
    logic [7:0] q[$];
    logic [15:0] c;
    logic [9:0] f;
    q = '{NODE, 8'h03, 8'h00, 8'h6B, 8'h00, 8'h01};
    c = crc16(q) ^ flip;
    q.push_back(c[15:8]);
    q.push_back(c[7:0]);
    foreach (q[i]) begin
      f = {1'b1, q[i], 1'b0};
      for (int k = 0; k < 10; k++) begin
        link2.ctl_txd = f[k];
        tick(4);
      end
    end
    tick(80);
  endtask : send2

  // A corrupted check word is dropped; after the gap a good one answers
  task automatic t_bad_crc();
    oe2_seen = 1'b0;
    send2(16'h0001);
    check("bad frame", {15'h0000, oe2_seen}, 16'h0000);
    tick(160);
    send2(16'h0000);
    check("good frame", {15'h0000, oe2_seen}, 16'h0001);
  endtask : t_bad_crc

  initial begin
    {rst_n_i, cmd_valid, oe2_seen} = 3'h0;
    {cmd_node, cmd_fn, cmd_addr, cmd_arg} = 48'h0;
    {n_errors, cmp_count, n_wr} = 0;
    reg_rdata = 16'h0000;
    link2.ctl_txd = 1'b1;
    for (int i = 0; i < 256; i++) regs[i] = 16'hC300 + 16'(i);
    tick(5);
    rst_n_i = 1'b1;
    tick(2);
    t_read(16'h006B, 8'h01);
    t_read(16'h008C, 8'h03);
    t_read(16'h0010, 8'h10);
    t_write(16'h0001, 16'h0003);
    t_read(16'h0000, 8'h02);
    t_other_node();
    t_refused(8'h03, 16'h0011);
    t_refused(8'h04, 16'h0001);
    t_bad_crc();
    give_verdict();
  end
endmodule : tb

`default_nettype wire
